// ### verilog/fecc_flash_dev.sv
// Flash access end: fetch ECC error handling and program-rule checks.
// Assumes the partner keeps one read or program request in flight.
`timescale 1ns/1ps
module fecc_flash_dev #(
  parameter int MAIN_N = fecc_pkg::MAIN_WORDS,
  parameter int OTP_N  = fecc_pkg::OTP_WORDS
) (
  input  wire logic         sys_clk,
  input  wire logic         srst,
  fecc_if.dev               lnk,
  input  wire logic         sbe_inject,
  output logic [7:0]        thr_value
);
  import fecc_pkg::*;

  // Faulty-word emulation: one fetch address holds a persistent flaw
  logic              fault_seen_q;
  logic              fault_seen_d;
  logic [ADDR_W-1:0] fault_addr_q;
  logic [ADDR_W-1:0] fault_addr_d;
  // Threshold, error counter and interrupt
  logic [THR_W-1:0]  thr_q;
  logic [THR_W-1:0]  thr_d;
  logic [CNT_W-1:0]  cnt_q;
  logic [CNT_W-1:0]  cnt_d;
  logic              irq_q;
  logic              irq_d;
  // Read answer
  logic              rd_done_q;
  logic              rd_done_d;
  logic              rd_sbe_q;
  logic              rd_sbe_d;
  // Program answer and tracker handshake
  logic              prg_done_q;
  logic              prg_done_d;
  logic [1:0]        prg_err_q;
  logic [1:0]        prg_err_d;
  logic              sbe_now;
  logic              main_used;
  logic              otp_used;
  logic              main_mark;
  logic              otp_mark;

  // Address bits below the unit size must all be zero
  function automatic logic misaligned(input logic [ADDR_W-1:0] a, input int lsb);
    logic [ADDR_W-1:0] m;
    m = (ADDR_W'(1) << lsb) - ADDR_W'(1);
    return (a & m) != '0;
  endfunction

  // Pointer words take bitwise updates, so the tracker never locks them
  function automatic logic is_pointer_word(input logic [ADDR_W-1:0] a);
    logic [3:0] w;
    w = a[OTP_ALIGN_LSB +: 4];
    return (w == OTP_LP12_IDX) || (w == OTP_LP3_IDX);
  endfunction

  // A flaw stays in the word, so the refetch sees it again
  assign sbe_now = lnk.rd_valid && (sbe_inject ||
                   (fault_seen_q && lnk.rd_is_fetch && lnk.rd_addr == fault_addr_q));

  // Fault memory next-state: only fetches remember the flaw
  always_comb begin
    fault_seen_d = fault_seen_q;
    fault_addr_d = fault_addr_q;
    if (sbe_now && lnk.rd_is_fetch) begin
      fault_seen_d = 1'b1;
      fault_addr_d = lnk.rd_addr;
    end
  end

  // Data reads leave the memory alone, so they never loop
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fault_seen_q <= 1'b0;
      fault_addr_q <= '0;
    end else begin
      fault_seen_q <= fault_seen_d;
      fault_addr_q <= fault_addr_d;
    end
  end

  // Read, threshold and interrupt next-state
  always_comb begin
    thr_d     = thr_q;
    cnt_d     = cnt_q;
    irq_d     = irq_q;
    rd_done_d = lnk.rd_valid;
    rd_sbe_d  = sbe_now;
    if (lnk.thr_we) begin
      thr_d = lnk.thr_wdata;
    end
    if (lnk.irq_ack) begin
      irq_d = 1'b0;
    end
    if (sbe_now) begin
      // Saturates rather than wraps, a wrap would hide an error storm
      if (cnt_q != '1) begin
        cnt_d = cnt_q + CNT_W'(1);
      end
      // Set beats ack in the same cycle
      if (cnt_d > thr_q) begin
        irq_d = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      thr_q     <= THR_RESET;
      cnt_q     <= '0;
      irq_q     <= 1'b0;
      rd_done_q <= 1'b0;
      rd_sbe_q  <= 1'b0;
    end else begin
      thr_q     <= thr_d;
      cnt_q     <= cnt_d;
      irq_q     <= irq_d;
      rd_done_q <= rd_done_d;
      rd_sbe_q  <= rd_sbe_d;
    end
  end

  // Program checks: refusal priority align, then partial, then twice
  always_comb begin
    prg_done_d = lnk.prg_valid;
    prg_err_d  = ERR_NONE;
    main_mark  = 1'b0;
    otp_mark   = 1'b0;
    if (lnk.prg_valid) begin
      if (lnk.prg_otp) begin
        // No partial check here: OTP units are always written whole
        if (misaligned(lnk.prg_addr, OTP_ALIGN_LSB)) begin
          prg_err_d = ERR_ALIGN;
        end else if (is_pointer_word(lnk.prg_addr)) begin
          prg_err_d = ERR_NONE;
        end else if (otp_used) begin
          prg_err_d = ERR_TWICE;
        end else begin
          otp_mark = 1'b1;
        end
      end else begin
        // Data-only under a full unit would leave its ECC slot stale
        if (misaligned(lnk.prg_addr, MAIN_ALIGN_LSB)) begin
          prg_err_d = ERR_ALIGN;
        end else if (lnk.prg_mode == PM_DATA_ONLY && !lnk.prg_full) begin
          prg_err_d = ERR_PARTIAL;
        end else if (main_used) begin
          prg_err_d = ERR_TWICE;
        end else begin
          main_mark = 1'b1;
        end
      end
    end
  end

  // Answer registered, one cycle after the request
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prg_done_q <= 1'b0;
      prg_err_q  <= ERR_NONE;
    end else begin
      prg_done_q <= prg_done_d;
      prg_err_q  <= prg_err_d;
    end
  end

  // Main array is erasable, OTP never is
  fecc_word_track #(.WORDS(MAIN_N), .IDX_W($clog2(MAIN_N))) u_main (
    .sys_clk (sys_clk),
    .srst    (srst),
    .clear   (lnk.erase),
    .idx     (lnk.prg_addr[MAIN_ALIGN_LSB +: $clog2(MAIN_N)]),
    .mark    (main_mark),
    .used    (main_used)
  );

  // No clear: once an OTP word is written it stays written
  fecc_word_track #(.WORDS(OTP_N), .IDX_W($clog2(OTP_N))) u_otp (
    .sys_clk (sys_clk),
    .srst    (srst),
    .clear   (1'b0),
    .idx     (lnk.prg_addr[OTP_ALIGN_LSB +: $clog2(OTP_N)]),
    .mark    (otp_mark),
    .used    (otp_used)
  );

  // Every link output comes straight from a flop
  assign lnk.rd_done   = rd_done_q;
  assign lnk.rd_sbe    = rd_sbe_q;
  assign lnk.sbe_irq   = irq_q;
  assign lnk.err_count = cnt_q;
  assign lnk.prg_done  = prg_done_q;
  assign lnk.prg_err   = prg_err_q;
  assign thr_value     = thr_q;
endmodule // fecc_flash_dev

// ### verilog/fecc_pkg.sv
// Package for the flash ECC and program-rule block.
// Assumes a single 100 MHz sys_clk domain shared by both ends.
package fecc_pkg;
  localparam int ADDR_W         = 24;     // Byte address width
  localparam int THR_W          = 8;      // Threshold field width
  localparam int CNT_W          = 8;      // Error counter width
  localparam logic [7:0] THR_RESET = 8'h00; // Threshold after reset
  localparam int MAIN_ALIGN_LSB = 3;      // 64-bit units, byte address
  localparam int OTP_ALIGN_LSB  = 4;      // 128-bit units, byte address
  localparam int MAIN_WORDS     = 64;     // Tracked main-array words
  localparam int OTP_WORDS      = 16;     // Tracked OTP words
  localparam logic [3:0] OTP_LP12_IDX = 4'h0; // Word holding pointers one/two
  localparam logic [3:0] OTP_LP3_IDX  = 4'h1; // Word holding pointer three

  // Program modes
  typedef enum logic [1:0] {
    PM_GEN_ECC   = 2'h0,  // program_with_generated_ecc
    PM_DATA_ECC  = 2'h1,  // program_data_with_supplied_ecc
    PM_DATA_ONLY = 2'h2   // program_data_without_ecc
  } fecc_pmode_t;

  // Refusal codes
  localparam logic [1:0] ERR_NONE    = 2'h0;
  localparam logic [1:0] ERR_ALIGN   = 2'h1;
  localparam logic [1:0] ERR_TWICE   = 2'h2;
  localparam logic [1:0] ERR_PARTIAL = 2'h3;
endpackage

// ### verilog/fecc_if.sv
// Interface joining the flash access end and the software/fetch end.
// Assumes both ends run on the same clock and synchronous reset.
`timescale 1ns/1ps
interface fecc_if;
  import fecc_pkg::*;
  // Fetch / read path
  logic                  rd_valid;
  logic                  rd_is_fetch;
  logic [ADDR_W-1:0]     rd_addr;
  logic                  rd_done;
  logic                  rd_sbe;
  logic                  sbe_irq;
  logic                  irq_ack;
  logic [THR_W-1:0]      thr_wdata;
  logic                  thr_we;
  logic [CNT_W-1:0]      err_count;
  // Program path
  logic                  prg_valid;
  logic                  prg_otp;
  fecc_pmode_t           prg_mode;
  logic [ADDR_W-1:0]     prg_addr;
  logic                  prg_full;
  logic                  erase;
  logic                  prg_done;
  logic [1:0]            prg_err;

  modport dev (
    input  rd_valid, rd_is_fetch, rd_addr, irq_ack, thr_wdata, thr_we,
           prg_valid, prg_otp, prg_mode, prg_addr, prg_full, erase,
    output rd_done, rd_sbe, sbe_irq, err_count, prg_done, prg_err
  );
  modport sw (
    output rd_valid, rd_is_fetch, rd_addr, irq_ack, thr_wdata, thr_we,
           prg_valid, prg_otp, prg_mode, prg_addr, prg_full, erase,
    input  rd_done, rd_sbe, sbe_irq, err_count, prg_done, prg_err
  );
endinterface

// ### verilog/fecc_word_track.sv
// Once-only tracker for program words, one bit per word.
// Assumes index is valid whenever check or mark is asserted.
`timescale 1ns/1ps
module fecc_word_track #(
  parameter int WORDS = 64,
  parameter int IDX_W = 6
) (
  input  wire logic             sys_clk,
  input  wire logic             srst,
  input  wire logic             clear,
  input  wire logic [IDX_W-1:0] idx,
  input  wire logic             mark,
  output logic                  used
);
  logic [WORDS-1:0] used_q;
  logic [WORDS-1:0] used_d;

  // Clear wins over mark, an erase empties the whole array
  always_comb begin
    used_d = used_q;
    if (clear) begin
      used_d = '0;
    end else if (mark) begin
      used_d[idx] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      used_q <= '0;
    end else begin
      used_q <= used_d;
    end
  end

  assign used = used_q[idx];
endmodule // fecc_word_track

// ### verilog/fecc_sw_end.sv
// Software/fetch end: threshold setup, fetch with refetch, program calls.
// Assumes the device answers every request one cycle later.
`timescale 1ns/1ps
module fecc_sw_end (
  input  wire logic                       sys_clk,
  input  wire logic                       srst,
  fecc_if.sw                              lnk,
  input  wire logic [fecc_pkg::THR_W-1:0] cfg_thr,
  input  wire logic                       fetch_req,
  input  wire logic                       fetch_is_code,
  input  wire logic [fecc_pkg::ADDR_W-1:0] fetch_addr,
  input  wire logic                       prog_req,
  input  wire logic                       prog_otp,
  input  wire fecc_pkg::fecc_pmode_t      prog_mode,
  input  wire logic [fecc_pkg::ADDR_W-1:0] prog_addr,
  input  wire logic                       prog_full,
  input  wire logic                       erase_req,
  output logic                            busy,
  output logic [1:0]                      last_err
);
  import fecc_pkg::*;

  typedef enum {S_INIT, S_IDLE, S_RD, S_ISR, S_PRG} fecc_sw_st_t;
  fecc_sw_st_t st_q, st_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic              code_q, code_d;
  logic [1:0]        err_q, err_d;

  // Sequencer: one request at a time, refetch after the handler
  always_comb begin
    st_d   = st_q;
    addr_d = addr_q;
    code_d = code_q;
    err_d  = err_q;
    case (st_q)
      S_INIT: st_d = S_IDLE; // Threshold written here, at least one
      S_IDLE: begin
        if (fetch_req) begin
          st_d = S_RD;
          addr_d = fetch_addr;
          code_d = fetch_is_code;
        end else if (prog_req) begin
          st_d = S_PRG;
          addr_d = prog_addr;
        end
      end
      S_RD: begin
        if (lnk.rd_done) begin
          st_d = lnk.sbe_irq ? S_ISR : S_IDLE;
        end
      end
      // Only a fetch returns to the faulting instruction, a data read moves on
      S_ISR: st_d = code_q ? S_RD : S_IDLE; // Handler acks, same address fetched again
      S_PRG: begin
        if (lnk.prg_done) begin
          err_d = lnk.prg_err;
          st_d  = S_IDLE;
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q   <= S_INIT;
      addr_q <= '0;
      code_q <= 1'b0;
      err_q  <= ERR_NONE;
    end else begin
      st_q   <= st_d;
      addr_q <= addr_d;
      code_q <= code_d;
      err_q  <= err_d;
    end
  end

  // Zero is clamped to one, so the handler loop cannot start before the second error
  assign lnk.thr_we      = (st_q == S_INIT);
  assign lnk.thr_wdata   = (cfg_thr == '0) ? THR_W'(1) : cfg_thr;
  assign lnk.rd_valid    = (st_q == S_RD) && !lnk.rd_done;
  assign lnk.rd_is_fetch = code_q;
  assign lnk.rd_addr     = addr_q;
  assign lnk.irq_ack     = (st_q == S_ISR);
  assign lnk.prg_valid   = (st_q == S_PRG) && !lnk.prg_done;
  assign lnk.prg_otp     = prog_otp;
  assign lnk.prg_mode    = prog_mode;
  assign lnk.prg_addr    = addr_q;
  assign lnk.prg_full    = prog_full;
  assign lnk.erase       = erase_req && (st_q == S_IDLE);
  assign busy            = (st_q != S_IDLE);
  assign last_err        = err_q;
endmodule // fecc_sw_end

// ### tb/fecc_properties.sv
// Concurrent checks on the link between the flash end and the software end.
// Assumes one sys_clk domain with synchronous active-high srst.
`timescale 1ns/1ps
module fecc_properties (
  input wire logic       sys_clk,
  input wire logic       srst,
  input wire logic       rd_valid,
  input wire logic       rd_done,
  input wire logic       rd_sbe,
  input wire logic       sbe_irq,
  input wire logic       irq_ack,
  input wire logic [7:0] err_count,
  input wire logic       prg_valid,
  input wire logic       prg_done,
  input wire logic [1:0] prg_err
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Steps of a read and of a quiet stretch
  sequence s_rd_req; $rose(rd_valid); endsequence
  sequence s_quiet; !rd_sbe ##1 !rd_sbe; endsequence
  // Answers come exactly one cycle after the request
  a_rd_answer_next: assert property (s_rd_req |=> rd_done) else $error("read not answered next cycle");
  a_prg_answer_next: assert property ($rose(prg_valid) |=> prg_done) else $error("program not answered");
  a_done_one_cycle: assert property (rd_done |=> !rd_done) else $error("read done held too long");
  a_sbe_with_done: assert property (rd_sbe |-> rd_done) else $error("error flag outside read answer");
  a_irq_from_error: assert property ($rose(sbe_irq) |-> rd_sbe) else $error("irq without error");
  a_irq_gets_ack: assert property ($rose(sbe_irq) |-> ##[1:4] irq_ack) else $error("irq not acked");
  // Count moves only with a flagged read, never on its own
  a_count_quiet: assert property (s_quiet |-> $stable(err_count)) else $error("count moved");
  a_refuse_done: assert property (prg_err != 2'h0 |-> prg_done) else $error("refusal off answer");
  a_reset_clean: assert property ($fell(srst) |-> err_count == 8'h00 && !sbe_irq) else $error("reset dirty");
endmodule // fecc_properties

// ### tb/tb.sv
// Self-checking bench: both ends joined, software end's user side driven.
// Assumes package, interface and design modules compile first.
`timescale 1ns/1ps
module tb;
  import fecc_pkg::*;
  logic              sys_clk = 1'b0;
  logic              srst = 1'b1;
  logic              sbe_inject = 1'b0;
  logic [7:0]        thr_value;
  logic [7:0]        cfg_thr = 8'h00;
  logic              fetch_req = 1'b0;
  logic              fetch_is_code = 1'b0;
  logic              prog_req = 1'b0;
  logic              prog_otp = 1'b0;
  logic              prog_full = 1'b0;
  logic              erase_req = 1'b0;
  logic              busy;
  logic              irq_at_done = 1'b0;
  logic [ADDR_W-1:0] fetch_addr = '0;
  logic [ADDR_W-1:0] prog_addr = '0;
  fecc_pmode_t       prog_mode = PM_GEN_ECC;
  logic [1:0]        last_err;
  logic [31:0]       seed = 32'h6DFC169E;
  logic [23:0]       bad_q[$];
  bit                main_used[64];
  bit                otp_used[16];
  int                bad_count = 0;
  int                num_checks = 0;
  int                cyc = 0;
  int                cnt_m = 0;
  int                thr_m = 0;

  fecc_if lnk_if ();
  fecc_flash_dev u_fecc_flash_dev (.sys_clk(sys_clk), .srst(srst), .lnk(lnk_if.dev),
    .sbe_inject(sbe_inject), .thr_value(thr_value));
  fecc_sw_end u_fecc_sw_end (.sys_clk(sys_clk), .srst(srst), .lnk(lnk_if.sw), .cfg_thr(cfg_thr),
    .fetch_req(fetch_req), .fetch_is_code(fetch_is_code), .fetch_addr(fetch_addr), .prog_req(prog_req),
    .prog_otp(prog_otp), .prog_mode(prog_mode), .prog_addr(prog_addr), .prog_full(prog_full),
    .erase_req(erase_req), .busy(busy), .last_err(last_err));
  fecc_properties u_props (.sys_clk(sys_clk), .srst(srst), .rd_valid(lnk_if.rd_valid),
    .rd_done(lnk_if.rd_done), .rd_sbe(lnk_if.rd_sbe), .sbe_irq(lnk_if.sbe_irq), .irq_ack(lnk_if.irq_ack),
    .err_count(lnk_if.err_count), .prg_valid(lnk_if.prg_valid), .prg_done(lnk_if.prg_done),
    .prg_err(lnk_if.prg_err));

  always #5 sys_clk = ~sys_clk;
  // Irq is acked soon after, so catch it beside the read answer
  always @(posedge sys_clk) begin
    cyc++;
    if (lnk_if.rd_done === 1'b1) irq_at_done <= lnk_if.sbe_irq;
    if (cyc == 3000) begin
      bad_count++;
      final_report();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Bounded overall by the cycle ceiling above
  task automatic wait_idle();
    while (busy !== 1'b0) tick(1);
  endtask
  task automatic do_reset(logic [7:0] t);
    srst = 1'b1;
    cfg_thr = t;
    cnt_m = 0;
    thr_m = (t == 8'h00) ? 1 : t;
    main_used = '{default: 0};
    otp_used = '{default: 0};
    bad_q.delete();
    tick(4);
    chk("thr_value", THR_RESET, thr_value);
    srst = 1'b0;
    tick(3);
    chk("thr_value", 8'(thr_m), thr_value);
  endtask
  // A flagged fetch address stays faulty, so later fetches count again
  task automatic rd(logic code, logic [23:0] a, logic inj);
    bit hit;
    hit = inj;
    foreach (bad_q[i]) if (code && bad_q[i] == a) hit = 1;
    if (code && inj) bad_q.push_back(a);
    cnt_m += hit;
    wait_idle();
    fetch_is_code = code;
    fetch_addr = a;
    sbe_inject = inj;
    fetch_req = 1'b1;
    tick(1);
    fetch_req = 1'b0;
    wait_idle();
    sbe_inject = 1'b0;
    chk("err_count", 8'(cnt_m), lnk_if.err_count);
    if (hit) chk("sbe_irq", {7'h0, cnt_m > thr_m}, {7'h0, irq_at_done});
  endtask
  task automatic prog(logic otp, fecc_pmode_t m, logic [23:0] a, logic full);
    logic [1:0] e;
    int i;
    i = otp ? a[7:4] : a[8:3];
    e = ERR_NONE;
    if (otp ? a[3:0] != 4'h0 : a[2:0] != 3'h0) e = ERR_ALIGN;
    else if (!otp && m == PM_DATA_ONLY && !full) e = ERR_PARTIAL;
    else if (otp ? (i > 1 && otp_used[i]) : main_used[i]) e = ERR_TWICE;
    if (e == ERR_NONE && otp) otp_used[i] = (i > 1);
    if (e == ERR_NONE && !otp) main_used[i] = 1;
    wait_idle();
    prog_otp = otp;
    prog_mode = m;
    prog_addr = a;
    prog_full = full;
    prog_req = 1'b1;
    tick(1);
    prog_req = 1'b0;
    wait_idle();
    tick(1);
    chk("last_err", {6'h0, e}, {6'h0, last_err});
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    // Threshold zero asked for, clamped to one; data reads only
    do_reset(8'h00);
    for (int k = 0; k < 4; k++) rd(1'b0, ADDR_W'(xs()), k < 2);
    $display("test data reads done");
    // Fetch faults under a higher threshold, refetch re-flags
    do_reset(8'h05);
    rd(1'b1, 24'h000100, 1'b1);
    rd(1'b1, 24'h000100, 1'b0);
    rd(1'b0, 24'h000100, 1'b0);
    rd(1'b1, 24'h000200, 1'b0);
    $display("test fetch faults done");
    prog(1'b0, PM_GEN_ECC, 24'h000008, 1'b1);
    prog(1'b0, PM_DATA_ECC, 24'h000008, 1'b1);
    prog(1'b0, PM_GEN_ECC, 24'h00000C, 1'b1);
    prog(1'b0, PM_DATA_ONLY, 24'h000010, 1'b0);
    prog(1'b0, PM_DATA_ONLY, 24'h000018, 1'b1);
    prog(1'b0, PM_DATA_ECC, 24'h0001F8, 1'b1);
    wait_idle();
    erase_req = 1'b1;
    tick(1);
    erase_req = 1'b0;
    tick(2);
    main_used = '{default: 0};
    prog(1'b0, PM_GEN_ECC, 24'h000008, 1'b1);
    prog(1'b1, PM_GEN_ECC, 24'h000028, 1'b1);
    for (int k = 0; k < 2; k++) prog(1'b1, PM_GEN_ECC, 24'h000020, 1'b1);
    for (int k = 0; k < 2; k++) prog(1'b1, PM_DATA_ONLY, 24'h000000, 1'b1);
    for (int k = 0; k < 2; k++) prog(1'b1, PM_DATA_ONLY, 24'h000010, 1'b1);
    $display("test programming done");
    final_report();
  end
endmodule // tb
